// >>> design/aof_top.v
// Top of the ADC oversampling and averaging filter with its APB slave.
// Assumes conversion results arrive on pclk from ADC core logic, one strobe
// per result, tagged with the channel that produced them.
//
// Function
// - Filter accumulates only while filter_on, control bit 15, is one.
// - Clearing filter_on also clears the result-ready flag.
// - Mode 11 selects averaging, 00 oversampling; 01 and 10 reserved.
// - Oversampling code 110 sums 32 samples into a 12.3 result.
// - Oversampling code 100 sums 2 samples into a 12.1 result.
// - Oversampling code 000 sums 4 samples into a 12.1 result.
// - One oversampling code sums 256 samples into a 12.4 result.
// - One oversampling code sums 16 samples into a 12.2 result.
// - Ratio bits 12-10 select averaging over 2 to 256 samples.
// - filter_irq_on, bit 9, lets a ready result raise the interrupt.
// - Hardware sets the ready flag, bit 8, when a result completes.
`timescale 1ns/1ps
`include "aof_consts.vh"

module aof_top (
    input  wire                       pclk,
    input  wire                       presetn,
    input  wire                       psel,
    input  wire                       penable,
    input  wire                       pwrite,
    input  wire [7:0]                 paddr,
    input  wire [31:0]                pwdata,
    input  wire [3:0]                 pstrb,
    output reg  [31:0]                prdata,
    output reg                        pready,
    output reg                        pslverr,
    input  wire                       sample_valid,
    input  wire [`AOF_SAMPLE_W-1:0]   sample_data,
    input  wire [4:0]                 sample_channel,
    output reg                        irq
);

    // Control register fields.
    reg        filter_on_reg;
    reg [1:0]  mode_reg;
    reg [2:0]  ratio_select_reg;
    reg        filter_irq_on_reg;
    reg        ready_reg;
    reg        ready_next;
    reg [4:0]  filter_channel_select_reg;

    // Interrupt status and mask.
    reg [1:0]  irq_status_reg;
    reg [1:0]  irq_status_next;
    reg [1:0]  irq_mask_reg;

    // Decoded filter settings.
    reg [3:0]  log2_count;
    reg [3:0]  shift;
    reg        mode_legal;

    wire        access;
    wire        wr_en;
    wire        rd_result;
    wire        wr_control;
    wire        setup;
    wire        run;
    wire        take_sample;
    wire        acc_clear;
    wire        acc_done;
    wire [15:0] filter_result_word;
    wire [15:0] control_word;
    wire        addr_mapped;
    wire        wr_ctl_hi;
    wire        wr_ctl_lo;
    wire        wr_status;
    wire        wr_mask;
    wire        rd_setup;
    wire        chan_match;

    // Every transfer ends in its first access cycle, so access needs pready.
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr_en  = access & pwrite;
    assign rd_result  = access & ~pwrite & (paddr == `AOF_OFS_RESULT);
    assign rd_setup   = setup & ~pwrite;

    // One strobe per writable byte lane; a lane that is off keeps its bits.
    assign wr_ctl_hi = wr_en & (paddr == `AOF_OFS_CONTROL) & pstrb[1];
    assign wr_ctl_lo = wr_en & (paddr == `AOF_OFS_CONTROL) & pstrb[0];
    assign wr_status = wr_en & (paddr == `AOF_OFS_IRQ_STATUS) & pstrb[0];
    assign wr_mask   = wr_en & (paddr == `AOF_OFS_IRQ_MASK) & pstrb[0];
    assign wr_control = wr_ctl_hi | wr_ctl_lo;

    // Unmapped words answer with an error, read as zero and drop writes.
    assign addr_mapped = (paddr == `AOF_OFS_CONTROL)    |
                         (paddr == `AOF_OFS_RESULT)     |
                         (paddr == `AOF_OFS_IRQ_STATUS) |
                         (paddr == `AOF_OFS_IRQ_MASK);

    // Bits 7 to 5 are not implemented and always read back as zero.
    assign control_word = {filter_on_reg,
                           mode_reg,
                           ratio_select_reg,
                           filter_irq_on_reg,
                           ready_reg,
                           3'h0,
                           filter_channel_select_reg};

    // Ratio and mode decode into a sample count and a final right shift.
    always @* begin
        log2_count = 4'h1;
        shift      = 4'h0;
        mode_legal = 1'b0;
        case (mode_reg)
            `AOF_MODE_OVERSAMPLE: begin
                mode_legal = 1'b1;
                case (ratio_select_reg)
                    3'h0: begin
                        log2_count = 4'h2;
                        shift      = 4'h1;
                    end
                    3'h1: begin
                        log2_count = 4'h4;
                        shift      = 4'h2;
                    end
                    3'h2: begin
                        log2_count = 4'h6;
                        shift      = 4'h3;
                    end
                    3'h3: begin
                        log2_count = 4'h8;
                        shift      = 4'h4;
                    end
                    3'h4: begin
                        log2_count = 4'h1;
                        shift      = 4'h0;
                    end
                    3'h5: begin
                        log2_count = 4'h3;
                        shift      = 4'h1;
                    end
                    3'h6: begin
                        log2_count = 4'h5;
                        shift      = 4'h2;
                    end
                    3'h7: begin
                        log2_count = 4'h7;
                        shift      = 4'h3;
                    end
                    default: begin
                        // All eight codes are listed above.
                        log2_count = 4'h1;
                        shift      = 4'h0;
                    end
                endcase
            end
            `AOF_MODE_AVERAGE: begin
                // The average keeps the 12-bit integer part only.
                mode_legal = 1'b1;
                log2_count = {1'b0, ratio_select_reg} + 4'h1;
                shift      = {1'b0, ratio_select_reg} + 4'h1;
            end
            default: begin
                // A reserved mode leaves the filter idle rather than guessing
                // at a scaling that software never asked for.
                mode_legal = 1'b0;
            end
        endcase
    end

    // Filter off and a reserved mode both hold the sum at zero, so every
    // restart begins from an empty block.
    assign run         = filter_on_reg & mode_legal;
    // Results of other channels pass by; only the selected one is summed.
    assign chan_match  = (sample_channel == filter_channel_select_reg);
    assign take_sample = run & sample_valid & chan_match;
    // Any control write that strobes byte lane 0 or 1 restarts the sum so one block never mixes settings.
    assign acc_clear   = ~run | wr_control;

    // The done pulse comes one cycle after the last sample is taken; ready
    // and status follow one cycle later and the pin one cycle after that,
    // so software polling ready never sees a result half written.
    aof_accum u_accum (
        .pclk         (pclk),
        .presetn      (presetn),
        .clear        (acc_clear),
        .sample_valid (take_sample),
        .sample_data  (sample_data),
        .log2_count   (log2_count),
        .shift        (shift),
        .done         (acc_done),
        .result       (filter_result_word)
    );

    // Ready flag: set by a finished result, cleared by reading the result
    // word, forced clear while the filter is off. A set wins over a read.
    always @* begin
        ready_next = ready_reg;
        if (rd_result) begin
            ready_next = 1'b0;
        end
        if (acc_done) begin
            ready_next = 1'b1;
        end
        if (!filter_on_reg) begin
            ready_next = 1'b0;
        end
    end

    // Sticky events: done, and overrun when a result lands while the last
    // one was still unread. Write one to clear; a new event wins.
    always @* begin
        irq_status_next = irq_status_reg;
        if (wr_status) begin
            irq_status_next = irq_status_reg & ~pwdata[1:0];
        end
        if (acc_done) begin
            irq_status_next[`AOF_IRQ_DONE_BIT] = 1'b1;
            if (ready_reg && !rd_result) begin
                irq_status_next[`AOF_IRQ_OVER_BIT] = 1'b1;
            end
        end
    end

    // Control register and the hardware-managed ready bit.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_on_reg             <= 1'b0;
            mode_reg                  <= `AOF_RST_MODE;
            ratio_select_reg          <= `AOF_RST_RATIO;
            filter_irq_on_reg         <= 1'b0;
            filter_channel_select_reg <= `AOF_RST_CHSEL;
            ready_reg                 <= 1'b0;
        end else begin
            ready_reg <= ready_next;
            // The ready bit and bits 7 to 5 take no write.
            if (wr_ctl_hi) begin
                filter_on_reg     <= pwdata[`AOF_CTL_ON_BIT];
                mode_reg          <= pwdata[`AOF_CTL_MODE_HI:
                                            `AOF_CTL_MODE_LO];
                ratio_select_reg  <= pwdata[`AOF_CTL_RATIO_HI:
                                            `AOF_CTL_RATIO_LO];
                filter_irq_on_reg <= pwdata[`AOF_CTL_IRQ_ON_BIT];
            end
            if (wr_ctl_lo) begin
                filter_channel_select_reg <=
                    pwdata[`AOF_CTL_CHSEL_HI:`AOF_CTL_CHSEL_LO];
            end
        end
    end

    // Interrupt status, mask and the level output.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= `AOF_RST_IRQ;
            irq_mask_reg   <= `AOF_RST_IRQ;
            irq            <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            if (wr_mask) begin
                irq_mask_reg <= pwdata[1:0];
            end
            // Registered so the pin is glitch free; it trails status by one.
            irq <= filter_irq_on_reg &
                   (|(irq_status_reg & irq_mask_reg));
        end
    end

    // APB slave: data and response are prepared in the setup cycle, so each
    // transfer finishes after exactly one access cycle with no wait.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~addr_mapped;
            if (rd_setup) begin
                case (paddr)
                    `AOF_OFS_CONTROL: begin
                        prdata <= {16'h0000, control_word};
                    end
                    `AOF_OFS_RESULT: begin
                        prdata <= {16'h0000, filter_result_word};
                    end
                    `AOF_OFS_IRQ_STATUS: begin
                        prdata <= {30'h00000000, irq_status_reg};
                    end
                    `AOF_OFS_IRQ_MASK: begin
                        prdata <= {30'h00000000, irq_mask_reg};
                    end
                    default: begin
                        prdata <= 32'h00000000;
                    end
                endcase
            end else if (access) begin
                // Back to zero after the access, so no stale word lingers.
                prdata <= 32'h00000000;
            end
        end
    end

endmodule

// >>> design/aof_consts.vh
// Constants for the ADC oversampling and averaging filter.
// Included by every filter design file; it holds definitions only.
`ifndef AOF_CONSTS_VH
`define AOF_CONSTS_VH

// APB byte addresses of the filter registers.
`define AOF_OFS_CONTROL      8'h00
`define AOF_OFS_RESULT       8'h04
`define AOF_OFS_IRQ_STATUS   8'h08
`define AOF_OFS_IRQ_MASK     8'h0C

// Field positions of the filter control register.
`define AOF_CTL_ON_BIT       15
`define AOF_CTL_MODE_HI      14
`define AOF_CTL_MODE_LO      13
`define AOF_CTL_RATIO_HI     12
`define AOF_CTL_RATIO_LO     10
`define AOF_CTL_IRQ_ON_BIT   9
`define AOF_CTL_READY_BIT    8
`define AOF_CTL_CHSEL_HI     4
`define AOF_CTL_CHSEL_LO     0

// Field positions of the interrupt status and mask registers.
`define AOF_IRQ_DONE_BIT     0
`define AOF_IRQ_OVER_BIT     1

// Filter mode codes.
`define AOF_MODE_OVERSAMPLE  2'h0
`define AOF_MODE_AVERAGE     2'h3

// Reset values.
`define AOF_RST_MODE         2'h0
`define AOF_RST_RATIO        3'h0
`define AOF_RST_CHSEL        5'h00
`define AOF_RST_RESULT       16'h0000
`define AOF_RST_IRQ          2'h0

// Widths of the data path.
`define AOF_SAMPLE_W         12
`define AOF_SUM_W            20
`define AOF_CNT_W            9

`endif

// >>> design/aof_accum.v
// Accumulator and scaler of the oversampling and averaging filter.
// Assumes one sample strobe per cycle at most, on the same clock, and a
// log2 count of 1 to 8 samples from the parent.
`timescale 1ns/1ps
`include "aof_consts.vh"

module aof_accum (
    input  wire                       pclk,
    input  wire                       presetn,
    input  wire                       clear,
    input  wire                       sample_valid,
    input  wire [`AOF_SAMPLE_W-1:0]   sample_data,
    input  wire [3:0]                 log2_count,
    input  wire [3:0]                 shift,
    output reg                        done,
    output reg  [15:0]                result
);

    reg  [`AOF_SUM_W-1:0] sum_reg;
    reg  [`AOF_CNT_W-1:0] cnt_reg;
    wire [`AOF_SUM_W-1:0] sum_new;
    wire [`AOF_SUM_W-1:0] sum_scaled;
    wire [`AOF_CNT_W-1:0] cnt_last;

    assign sum_new    = sum_reg + {8'h00, sample_data};
    assign sum_scaled = sum_new >> shift;
    assign cnt_last   = (9'h001 << log2_count) - 9'h001;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_reg <= 20'h00000;
            cnt_reg <= 9'h000;
            done    <= 1'b0;
            result  <= `AOF_RST_RESULT;
        end else if (clear) begin
            sum_reg <= 20'h00000;
            cnt_reg <= 9'h000;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (sample_valid) begin
                if (cnt_reg == cnt_last) begin
                    // The scaled sum is stored and a new block starts.
                    result  <= sum_scaled[15:0];
                    sum_reg <= 20'h00000;
                    cnt_reg <= 9'h000;
                    done    <= 1'b1;
                end else begin
                    sum_reg <= sum_new;
                    cnt_reg <= cnt_reg + 9'h001;
                end
            end
        end
    end

endmodule

// >>> sim/aof_adc_src.sv
// Model of the ADC core result path that feeds the filter's sample inputs.
// Assumes one bench process calls send at a time, on the filter's pclk.
`timescale 1ns/1ps
module aof_adc_src (
    input  wire         pclk,
    output logic        sample_valid,
    output logic [11:0] sample_data,
    output logic [4:0]  sample_channel
);
    initial begin
        sample_valid = 1'b0;
        sample_data = 12'h000;
        sample_channel = 5'h00;
    end
    // Outside a result the lines show the inverse, so stale data never helps.
    task automatic send(input logic [11:0] d, input logic [4:0] c, int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_data <= d;
        sample_channel <= c;
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_data <= ~d;
        sample_channel <= ~c;
    endtask
endmodule

// >>> sim/aof_top_sva.sv
// Checker for the filter top, bound to aof_top.
// Assumes it sees only the top's ports, on pclk with presetn.
`timescale 1ns/1ps
`include "aof_consts.vh"
module aof_top_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        sample_valid,
    input wire        irq
);
    logic off_reg;
    logic irq_on_reg;
    wire  ctl_sel = paddr == `AOF_OFS_CONTROL;
    wire  wr_done = psel && penable && pready && pwrite;
    wire  ctl_wr = wr_done && ctl_sel && pstrb[1];
    wire  mapped = ctl_sel || paddr == `AOF_OFS_RESULT
                   || paddr == `AOF_OFS_IRQ_STATUS || paddr == `AOF_OFS_IRQ_MASK;
    // Control bits are not ports, so they are mirrored from committed writes.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_reg <= 1'b1;
            irq_on_reg <= 1'b0;
        end else if (ctl_wr) begin
            off_reg <= !pwdata[15];
            irq_on_reg <= pwdata[9];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("answer held longer than one cycle");
    AST_SLVERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match address");
    AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside access cycle");
    AST_CTRL_ZERO: assert property (pready && !pwrite && ctl_sel |->
        prdata[31:16] == 16'h0000 && prdata[7:5] == 3'h0)
        else $error("unused control bits read nonzero");
    AST_OFF_NOT_READY: assert property (pready && !pwrite && ctl_sel
        && off_reg |-> prdata[15] == 1'b0 && prdata[8] == 1'b0)
        else $error("ready shown while filter off");
    AST_IRQ_GATED: assert property (!irq_on_reg && !$past(irq_on_reg)
        |-> !irq) else $error("interrupt while disabled");
    AST_IRQ_RISE: assert property ($rose(irq) |->
        $past(sample_valid, 3) || $past(wr_done, 2))
        else $error("interrupt rose without cause");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_done, 2))
        else $error("interrupt fell without a write");
    cover property (ctl_wr);
    cover property ($rose(irq));
    cover property (pready && pslverr);
endmodule
bind aof_top aof_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .irq(irq));

// >>> sim/testbench.sv
// Self-checking bench for the filter top with an ADC result source model.
// Assumes aof_consts.vh on the include path and a 50 ns pclk.
`timescale 1ns/1ps
`include "aof_consts.vh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  pstrb;
    wire  [31:0] prdata;
    wire         pready, pslverr, sample_valid, irq;
    wire  [11:0] sample_data;
    wire  [4:0]  sample_channel;
    integer      seed, miscompares, compares, cycles;
    aof_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_channel(sample_channel), .irq(irq));
    aof_adc_src src (.pclk(pclk), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_channel(sample_channel));
    always #25 pclk = ~pclk;
    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // The limit is far above the few thousand cycles the tests need.
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            results;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Look between edges: pready falls at the very edge that ends the
        // access, so sampling at that edge would race the design.
        do @(negedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask
    function automatic int n_of(input logic [1:0] m, input logic [2:0] r);
        int os[8] = '{4, 16, 64, 256, 2, 8, 32, 128};
        return (m == 2'h3) ? (2 << r) : os[r];
    endfunction
    function automatic int sh_of(input logic [1:0] m, input logic [2:0] r);
        int os[8] = '{1, 2, 3, 4, 0, 1, 2, 3};
        return (m == 2'h3) ? r + 1 : os[r];
    endfunction
    task automatic run(input logic [1:0] m, input logic [2:0] r, logic ie);
        logic [4:0]  ch;
        logic [31:0] d;
        int          sum;
        ch = $random(seed);
        sum = 0;
        xfer(1'b1, `AOF_OFS_CONTROL, {16'h0, 1'b1, m, r, ie, 4'h0, ch});
        for (int i = 0; i < n_of(m, r); i++) begin
            d = $random(seed);
            if (d[12])
                src.send(d[11:0], ch ^ 5'h01, 0);
            src.send(d[11:0], ch, d[13]);
            sum = sum + d[11:0];
        end
        xfer(1'b0, `AOF_OFS_CONTROL, 32'h00000000);
        check(rd[8], 1'b1);
        check(irq, ie);
        rd_chk(`AOF_OFS_RESULT, (sum >> sh_of(m, r)) & 16'hFFFF);
        xfer(1'b1, `AOF_OFS_IRQ_STATUS, 32'h00000003);
        rd_chk(`AOF_OFS_IRQ_STATUS, 32'h00000000);
        check(irq, 1'b0);
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        seed = 16;
        {miscompares, compares, cycles} = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            rd_chk(a * 4, 32'h00000000);
            check(err, a == 4);
        end
        xfer(1'b1, `AOF_OFS_CONTROL, 32'hFFFFFFFF);
        rd_chk(`AOF_OFS_CONTROL, 32'h0000FE1F);
        xfer(1'b1, `AOF_OFS_RESULT, 32'h0000FFFF);
        rd_chk(`AOF_OFS_RESULT, 32'h00000000);
        xfer(1'b1, `AOF_OFS_IRQ_MASK, 32'h00000003);
        rd_chk(`AOF_OFS_IRQ_MASK, 32'h00000003);
        for (int m = 0; m < 4; m += 3)
            for (int r = 0; r < 8; r++)
                run(m, r, r != 2);
        xfer(1'b1, `AOF_OFS_CONTROL, 32'h00009000);
        src.send(12'h123, 5'h00, 0);
        src.send(12'h456, 5'h00, 0);
        // A second block lands while the first is unread: overrun.
        src.send(12'h789, 5'h00, 0);
        src.send(12'h0AB, 5'h00, 0);
        rd_chk(`AOF_OFS_IRQ_STATUS, 32'h00000003);
        xfer(1'b1, `AOF_OFS_CONTROL, 32'h00000000);
        rd_chk(`AOF_OFS_CONTROL, 32'h00000000);
        rd_chk(`AOF_OFS_RESULT, 32'h00000834);
        xfer(1'b1, `AOF_OFS_IRQ_STATUS, 32'h00000003);
        for (int m = 0; m < 3; m++) begin
            xfer(1'b1, `AOF_OFS_CONTROL, {16'h0, m != 0, m[1:0], 13'h1000});
            src.send(12'hABC, 5'h00, 0);
            src.send(12'h321, 5'h00, 0);
            rd_chk(`AOF_OFS_IRQ_STATUS, 32'h00000000);
        end
        results;
    end
endmodule
